/* File: src/simd_exec_pkg.sv */
// Constants, register map and carrier types for the SIMD flow/compare unit.
// Assumes a single 50 MHz core clock and a 32-bit Avalon-MM register port.

package simd_exec_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int NCH     = 16;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int OFF_W   = 16;

  // ------------------------------------------------------------------
  // Opcodes and condition modifiers
  // ------------------------------------------------------------------
  localparam logic [6:0] OP_CMP   = 7'h10;
  localparam logic [6:0] OP_CASE  = 7'h26;
  localparam logic [6:0] OP_BREAK = 7'h28;

  localparam logic [3:0] CM_NONE = 4'h0;
  localparam logic [3:0] CM_EQ   = 4'h1;
  localparam logic [3:0] CM_NE   = 4'h2;
  localparam logic [3:0] CM_GT   = 4'h3;
  localparam logic [3:0] CM_GE   = 4'h4;
  localparam logic [3:0] CM_LT   = 4'h5;
  localparam logic [3:0] CM_LE   = 4'h6;

  // Execution size at or below this log2 uses one flag half
  localparam logic [2:0] HALF_LOG2 = 3'h3;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_INSTR  = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_OFFS   = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_DSTIMM = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_WMASK  = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_PREDICATE_CHANNEL_MASK  = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_IP     = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_GO     = 8'h18;
  localparam logic [ADDR_W-1:0] ADR_FLAG   = 8'h1c;
  localparam logic [ADDR_W-1:0] ADR_DLSB   = 8'h20;
  localparam logic [1:0]        RGN_PER_CHANNEL_POINTER   = 2'h1;
  localparam logic [1:0]        RGN_SRC0   = 2'h2;
  localparam logic [1:0]        RGN_SRC1   = 2'h3;

  localparam logic [DATA_W-1:0] RST_WORD   = 32'h0;
  localparam logic [NCH-1:0]    RST_MASK   = 16'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [13:0] rsvd;
    logic        spf_mode;
    logic        dst_null;
    logic        second_half_select;
    logic        pred_en;
    logic [2:0]  exec_log2;
    logic [3:0]  cmod;
    logic [6:0]  opcode;
  } instr_t;

  typedef struct packed {
    logic [OFF_W-1:0] update_off;
    logic [OFF_W-1:0] jump_off;
  } offs_t;

  typedef struct packed {
    logic [28:0] rsvd;
    logic        bad_cmod;
    logic        bad_opcode;
    logic        jump_taken;
  } status_t;

endpackage : simd_exec_pkg

/* File: src/simd_break_case_compare_exec.sv */
// Flow-control and compare execution for a 16-channel SIMD unit: early-exit,
// case-entry and component-wise compare, steered through Avalon-MM registers.
// Assumes a synchronous Avalon master on the same clock; no interrupts.
//
// Overview of operation
// RQ1: Opcode 0x28 decodes as early exit
// RQ2: Enabled channels get pointer plus update or one
// RQ3: All enabled channels hit: thread jumps by jump
// RQ4: Program sets loop update and jump targets
// RQ5: In switch: unpredicated, jump equals update
// RQ6: Update bits 31:16, jump bits 15:0, signed
// RQ7: Program never compresses exit or case
// RQ8: Opcode 0x26 decodes as case entry
// RQ9: Unselected channels take jump offset, others one
// RQ10: No channel selected: thread jumps by offset
// RQ11: Program aims case jump past matching exit
// RQ12: Case jump is signed bits 15:0 immediate
// RQ13: Program pairs predicate and modifier legally
// RQ14: Program closes each case with exit
// RQ15: Opcode 0x10 decodes as compare
// RQ16: Compare subtracts, evaluates condition, packs flags
// RQ17: Non-null destination gets flag in bit zero
// RQ18: Program never uses all-zero modifier on compare
// RQ19: Small execution size updates one flag half
// RQ20: Program avoids architecture destination and saturation
// RQ21: Program never mixes float and dword sources
// RQ22: Single-program-flow exit leaves pointers unchanged
// RQ23: Disabled channels write zero flag bits

`timescale 1ns/100ps
`default_nettype none

module simd_break_case_compare_exec
  import simd_exec_pkg::*;
(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST_B,
  input  wire logic [ADDR_W-1:0] I_ADDRESS,
  input  wire logic              I_READ,
  input  wire logic              I_WRITE,
  input  wire logic [3:0]        I_BYTEENABLE,
  input  wire logic [DATA_W-1:0] I_WRITEDATA,
  output logic      [DATA_W-1:0] O_READDATA,
  output logic                   O_WAITREQUEST
);

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} state_t;
  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  state_t              state_q;
  instr_t              ins_q;
  offs_t               offs_q;
  status_t             status_q;
  logic [OFF_W-1:0]    case_jip_q;
  logic [NCH-1:0]      channel_write_mask_q, predicate_channel_mask_q, flag_q, dst_lsb_q;
  logic [DATA_W-1:0]   ip_q, rd_q, rd_d;
  logic [DATA_W-1:0]   per_channel_pointer_q [NCH];
  logic [DATA_W-1:0]   src0_q [NCH], src1_q [NCH];
  logic                wait_q;
  logic                req, wr_go, exec, is_break, is_case, is_cmp;
  logic                all_hit, none_sel, cmod_known;
  logic [DATA_W-1:0]   ip_inc, uip_ext, jip_ext, case_jip_ext;
  logic [NCH-1:0]      chan_en, pm, cond_raw, cond_bit, sel;
  logic [DATA_W-1:0]   per_channel_pointer_brk [NCH], per_channel_pointer_case [NCH];
  logic [3:0]          idx;
  logic [1:0]          rgn;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [3:0]        be);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge
  // Signed integer compare; the NaN signal plays no part here
  function automatic logic cond_eval(input logic [3:0]        cm,
                                     input logic [DATA_W-1:0] a,
                                     input logic [DATA_W-1:0] b);
    logic [DATA_W:0] diff;
    logic            zero;
    logic            neg;
    logic            r;
    diff = {a[DATA_W-1], a} - {b[DATA_W-1], b};
    zero = (diff == {(DATA_W+1){1'b0}});
    neg  = diff[DATA_W];
    case (cm)
      CM_EQ:   r = zero;
      CM_NE:   r = !zero;
      CM_GT:   r = !zero && !neg;
      CM_GE:   r = !neg;
      CM_LT:   r = neg;
      CM_LE:   r = neg || zero;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : cond_eval

  // ------------------------------------------------------------------
  // Decode and per-channel evaluation
  // ------------------------------------------------------------------
  assign exec     = (state_q == ST_EXEC);
  assign is_break = (ins_q.opcode == OP_BREAK); // RQ1
  assign is_case  = (ins_q.opcode == OP_CASE);  // RQ8
  assign is_cmp   = (ins_q.opcode == OP_CMP);   // RQ15
  assign ip_inc   = ip_q + 32'h1;
  // Offsets count 64-bit instruction slots, added before the increment
  assign uip_ext      = {{OFF_W{offs_q.update_off[OFF_W-1]}}, offs_q.update_off}; // RQ6
  assign jip_ext      = {{OFF_W{offs_q.jump_off[OFF_W-1]}}, offs_q.jump_off};     // RQ6
  assign case_jip_ext = {{OFF_W{case_jip_q[OFF_W-1]}}, case_jip_q};               // RQ12
  assign cmod_known   = (ins_q.cmod >= CM_EQ) && (ins_q.cmod <= CM_LE);

  for (genvar n = 0; n < NCH; n++) begin : g_ch
    assign chan_en[n]  = channel_write_mask_q[n]
                         && ((5'(n) >> ins_q.exec_log2) == 5'h0);
    assign pm[n]       = ins_q.pred_en ? predicate_channel_mask_q[n] : 1'b1;
    assign cond_raw[n] = cond_eval(ins_q.cmod, src0_q[n], src1_q[n]); // RQ16
    assign cond_bit[n] = chan_en[n] & cond_raw[n];                    // RQ23
    assign sel[n]      = (ins_q.cmod == CM_NONE) ? pm[n] : cond_raw[n]; // RQ9
    assign per_channel_pointer_brk[n]  = pm[n] ? ip_q + uip_ext : ip_inc;      // RQ2
    assign per_channel_pointer_case[n] = sel[n] ? ip_inc : ip_q + case_jip_ext; // RQ9
  end
  // Empty channel set counts as not all hit, so an idle break falls through
  assign all_hit  = (chan_en != RST_MASK) && ((chan_en & ~pm) == RST_MASK); // RQ3
  assign none_sel = ((chan_en & sel) == RST_MASK);                          // RQ10

  // ------------------------------------------------------------------
  // Avalon slave: one wait state, then the access completes
  // ------------------------------------------------------------------
  assign req   = (I_READ || I_WRITE) && (state_q == ST_IDLE);
  assign idx   = I_ADDRESS[5:2];
  assign rgn   = I_ADDRESS[7:6];
  assign wr_go = I_WRITE && req && !wait_q && (I_ADDRESS == ADR_GO)
                 && I_BYTEENABLE[0] && I_WRITEDATA[0];

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  always_comb begin
    rd_d = UNMAPPED_RD;
    if (rgn == RGN_PER_CHANNEL_POINTER) begin
      rd_d = per_channel_pointer_q[idx];
    end else if (rgn == RGN_SRC0) begin
      rd_d = src0_q[idx];
    end else if (rgn == RGN_SRC1) begin
      rd_d = src1_q[idx];
    end else if (I_ADDRESS == ADR_INSTR) begin
      rd_d = ins_q;
    end else if (I_ADDRESS == ADR_OFFS) begin
      rd_d = offs_q;
    end else if (I_ADDRESS == ADR_DSTIMM) begin
      rd_d = {16'h0, case_jip_q};
    end else if (I_ADDRESS == ADR_WMASK) begin
      rd_d = {16'h0, channel_write_mask_q};
    end else if (I_ADDRESS == ADR_PREDICATE_CHANNEL_MASK) begin
      rd_d = {16'h0, predicate_channel_mask_q};
    end else if (I_ADDRESS == ADR_IP) begin
      rd_d = ip_q;
    end else if (I_ADDRESS == ADR_GO) begin
      rd_d = status_q;
    end else if (I_ADDRESS == ADR_FLAG) begin
      rd_d = {16'h0, flag_q};
    end else if (I_ADDRESS == ADR_DLSB) begin
      rd_d = {16'h0, dst_lsb_q};
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      rd_q <= RST_WORD;
    end else if (I_READ && req && wait_q) begin
      rd_q <= rd_d;
    end
  end
  assign O_READDATA    = rd_q;
  assign O_WAITREQUEST = wait_q;

  // ------------------------------------------------------------------
  // Sequencer: a go write starts a one-cycle execution
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (wr_go) begin
          state_q <= ST_EXEC;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Software-written instruction fields
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      ins_q                    <= RST_WORD;
      offs_q                   <= RST_WORD;
      case_jip_q               <= RST_MASK;
      channel_write_mask_q     <= RST_MASK;
      predicate_channel_mask_q <= RST_MASK;
      for (int k = 0; k < NCH; k++) begin
        src0_q[k] <= RST_WORD;
        src1_q[k] <= RST_WORD;
      end
    end else if (I_WRITE && req && !wait_q) begin
      if (rgn == RGN_SRC0) begin
        src0_q[idx] <= be_merge(src0_q[idx], I_WRITEDATA, I_BYTEENABLE);
      end else if (rgn == RGN_SRC1) begin
        src1_q[idx] <= be_merge(src1_q[idx], I_WRITEDATA, I_BYTEENABLE);
      end else if (I_ADDRESS == ADR_INSTR) begin
        ins_q <= be_merge(ins_q, I_WRITEDATA, I_BYTEENABLE);
      end else if (I_ADDRESS == ADR_OFFS) begin
        offs_q <= be_merge(offs_q, I_WRITEDATA, I_BYTEENABLE);
      end else if (I_ADDRESS == ADR_DSTIMM) begin
        case_jip_q <= 16'(be_merge({16'h0, case_jip_q}, I_WRITEDATA, I_BYTEENABLE));
      end else if (I_ADDRESS == ADR_WMASK) begin
        channel_write_mask_q <= 16'(be_merge({16'h0, channel_write_mask_q}, I_WRITEDATA,
                                             I_BYTEENABLE));
      end else if (I_ADDRESS == ADR_PREDICATE_CHANNEL_MASK) begin
        predicate_channel_mask_q <= 16'(be_merge({16'h0, predicate_channel_mask_q},
                                                 I_WRITEDATA, I_BYTEENABLE));
      end
    end
  end

  // ------------------------------------------------------------------
  // Thread and channel pointers
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      ip_q <= RST_WORD;
    end else if (exec) begin
      if (is_break && all_hit) begin
        ip_q <= ip_q + jip_ext;        // RQ3
      end else if (is_case && none_sel) begin
        ip_q <= ip_q + case_jip_ext;   // RQ10
      end else begin
        ip_q <= ip_inc;
      end
    end else if (I_WRITE && req && !wait_q && I_ADDRESS == ADR_IP) begin
      ip_q <= be_merge(ip_q, I_WRITEDATA, I_BYTEENABLE);
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      for (int k = 0; k < NCH; k++) begin
        per_channel_pointer_q[k] <= RST_WORD;
      end
    end else if (exec) begin
      for (int k = 0; k < NCH; k++) begin
        if (chan_en[k]) begin
          // Single-program-flow keeps every channel pointer frozen on break; case still updates them
          if (is_break && !ins_q.spf_mode) begin
            per_channel_pointer_q[k] <= per_channel_pointer_brk[k];  // RQ2 RQ22
          end else if (is_case) begin
            per_channel_pointer_q[k] <= per_channel_pointer_case[k]; // RQ9
          end
        end
      end
    end else if (I_WRITE && req && !wait_q && rgn == RGN_PER_CHANNEL_POINTER) begin
      per_channel_pointer_q[idx] <= be_merge(per_channel_pointer_q[idx], I_WRITEDATA,
                                             I_BYTEENABLE);
    end
  end

  // ------------------------------------------------------------------
  // Compare results
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      flag_q <= RST_MASK;
    end else if (exec && is_cmp) begin
      if (ins_q.exec_log2 <= HALF_LOG2) begin
        if (ins_q.second_half_select) begin
          flag_q[15:8] <= cond_bit[7:0]; // RQ19
        end else begin
          flag_q[7:0]  <= cond_bit[7:0]; // RQ19
        end
      end else begin
        flag_q <= cond_bit;              // RQ16 RQ23
      end
    end
  end
  // Upper destination bits are left to the register file; only bit 0 lives here
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      dst_lsb_q <= RST_MASK;
    end else if (exec && is_cmp && !ins_q.dst_null) begin
      for (int k = 0; k < NCH; k++) begin
        if (chan_en[k]) begin
          dst_lsb_q[k] <= cond_raw[k]; // RQ17
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      status_q <= RST_WORD;
    end else if (exec) begin
      status_q.jump_taken <= (is_break && all_hit) || (is_case && none_sel);
      status_q.bad_opcode <= !(is_break || is_case || is_cmp);
      status_q.bad_cmod   <= is_cmp && !cmod_known;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  break_update_a: assert property ( // RQ2
    exec && is_break && !ins_q.spf_mode && chan_en[0] && pm[0]
    |=> per_channel_pointer_q[0] == $past(ip_q) + $past(uip_ext))
    else $error("break update pointer wrong");
  break_spf_a: assert property ( // RQ22
    exec && is_break && ins_q.spf_mode
    |=> per_channel_pointer_q[3] == $past(per_channel_pointer_q[3]))
    else $error("pointer moved under single program flow");
  break_jump_a: assert property ( // RQ3
    exec && is_break && all_hit |=> ip_q == $past(ip_q) + $past(jip_ext))
    else $error("break jump missing");
  break_fall_a: assert property ( // RQ1
    exec && is_break && !all_hit |=> ip_q == $past(ip_q) + 32'h1)
    else $error("break fall-through wrong");
  case_skip_a: assert property ( // RQ9
    exec && is_case && chan_en[1] && !sel[1]
    |=> per_channel_pointer_q[1] == $past(ip_q) + $past(case_jip_ext))
    else $error("case skip pointer wrong");
  case_jump_a: assert property ( // RQ10
    exec && is_case && none_sel |=> ip_q == $past(ip_q) + $past(case_jip_ext))
    else $error("case jump missing");
  cmp_half_a: assert property ( // RQ19
    exec && is_cmp && ins_q.exec_log2 <= HALF_LOG2 && !ins_q.second_half_select
    |=> flag_q[15:8] == $past(flag_q[15:8]) && flag_q[7:0] == $past(cond_bit[7:0]))
    else $error("low flag half update wrong");
  cmp_disabled_a: assert property ( // RQ23
    exec && is_cmp && ins_q.exec_log2 > HALF_LOG2 && !chan_en[5] |=> !flag_q[5])
    else $error("disabled channel flag set");
  cmp_dst_a: assert property ( // RQ17
    exec && is_cmp && !ins_q.dst_null && chan_en[2] |=> dst_lsb_q[2] == $past(cond_raw[2]))
    else $error("destination bit wrong");
  bus_answer_a: assert property (
    req && wait_q |=> !O_WAITREQUEST ##1 O_WAITREQUEST)
    else $error("bus answer timing wrong");

endmodule : simd_break_case_compare_exec

`default_nettype wire

/* File: bench/instr_stream_master.sv */
// Model of the instruction stream producer: an Avalon-MM master issuing
// register accesses. Assumes a slave that answers through waitrequest.
`timescale 1ns/100ps
`default_nettype none

module instr_stream_master
  import simd_exec_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_waitrequest,
  output var  logic [ADDR_W-1:0] o_address,
  output var  logic              o_read,
  output var  logic              o_write,
  output var  logic [3:0]        o_byteenable,
  output var  logic [DATA_W-1:0] o_writedata
);
  initial begin
    o_address    = '0;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_byteenable = 4'hf;
    o_writedata  = '0;
  end

  // Integer sources only; no compression or accumulator target encodable
  task automatic access(input logic rw, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_address   <= a;
    o_writedata <= d;
    o_write     <= rw;
    o_read      <= !rw;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0) @(posedge i_clk);
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    // Released data lines must not keep the last value
    o_writedata <= ~d;
  endtask : access
endmodule : instr_stream_master

`default_nettype wire

/* File: bench/simd_break_case_compare_exec_tb.sv */
// Self-checking bench: runs break, case and compare programs over the bus
// and checks pointers, status and flags. Assumes the package register map.
`timescale 1ns/100ps
`default_nettype none

module simd_break_case_compare_exec_tb;
  import simd_exec_pkg::*;
  typedef struct packed {logic [DATA_W-1:0] val; logic [DATA_W-1:0] mask;} note_t;
  localparam int MAX_CYC = 20000;
  logic              clk_sys = 1'b0;
  logic              rst_b   = 1'b0;
  wire logic [ADDR_W-1:0] address;
  wire logic              rd_s;
  wire logic              wr_s;
  wire logic [3:0]        be;
  wire logic [DATA_W-1:0] wdata;
  wire logic [DATA_W-1:0] rdata;
  wire logic              wreq;
  note_t             exp_q[$];
  note_t             got;
  int                errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  logic [DATA_W-1:0] per_channel_pointer_m [NCH] = '{default: '0};
  logic [DATA_W-1:0] s0 [NCH];
  logic [DATA_W-1:0] s1 [NCH];
  logic [NCH-1:0]    flag_m = '0;
  logic [NCH-1:0]    dlsb_m = '0;

  always #10 clk_sys = ~clk_sys;

  simd_break_case_compare_exec simd_break_case_compare_exec_i (
    .I_CLK_SYS(clk_sys), .I_RST_B(rst_b), .I_ADDRESS(address), .I_READ(rd_s),
    .I_WRITE(wr_s), .I_BYTEENABLE(be), .I_WRITEDATA(wdata),
    .O_READDATA(rdata), .O_WAITREQUEST(wreq));

  instr_stream_master instr_stream_master_i (
    .i_clk(clk_sys), .i_waitrequest(wreq), .o_address(address), .o_read(rd_s),
    .o_write(wr_s), .o_byteenable(be), .o_writedata(wdata));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    instr_stream_master_i.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                    input logic [DATA_W-1:0] m);
    exp_q.push_back('{val: v, mask: m});
    instr_stream_master_i.access(1'b0, a, '0);
  endtask : rd

  function automatic logic [DATA_W-1:0] sx(input logic [OFF_W-1:0] o);
    return {{16{o[15]}}, o};
  endfunction : sx

  // Condition from the signed difference, no NaN term for integers
  function automatic logic cond_of(input logic [3:0] cm, input logic [DATA_W-1:0] a,
                                   input logic [DATA_W-1:0] b);
    logic signed [DATA_W:0] r;
    r = $signed({a[DATA_W-1], a}) - $signed({b[DATA_W-1], b});
    case (cm)
      CM_EQ:   return r == 0;
      CM_NE:   return r != 0;
      CM_GT:   return r > 0;
      CM_GE:   return r >= 0;
      CM_LT:   return r < 0;
      CM_LE:   return r <= 0;
      default: return 1'b0;
    endcase
  endfunction : cond_of

  // ------------------------------------------------------------------
  // One instruction: load, execute, predict, read back
  // ------------------------------------------------------------------
  task automatic run_op(input instr_t ins, input offs_t of, input logic [OFF_W-1:0] dj,
                        input logic [NCH-1:0] wm, input logic [NCH-1:0] pm);
    logic [DATA_W-1:0] ip0;
    logic [DATA_W-1:0] ip_e;
    logic [NCH-1:0]    bits;
    logic              en, pb, c, sel, any_en, all_hit, any_sel, jt, bad_cm;
    status_t           st;
    ip0 = $urandom;
    bits = '0;
    any_en = 1'b0;
    all_hit = 1'b1;
    any_sel = 1'b0;
    wr(ADR_IP, ip0);
    wr(ADR_INSTR, ins);
    wr(ADR_OFFS, of);
    wr(ADR_DSTIMM, {16'h0, dj});
    wr(ADR_WMASK, {16'h0, wm});
    wr(ADR_PREDICATE_CHANNEL_MASK, {16'h0, pm});
    for (int n = 0; n < NCH; n++) begin
      s0[n] = 32'($urandom_range(0, 4)) - 32'h2;
      s1[n] = 32'($urandom_range(0, 4)) - 32'h2;
      wr({RGN_SRC0, 4'(n), 2'h0}, s0[n]);
      wr({RGN_SRC1, 4'(n), 2'h0}, s1[n]);
    end
    wr(ADR_GO, 32'h1);
    bad_cm = ins.opcode == OP_CMP && (ins.cmod == CM_NONE || ins.cmod > CM_LE);
    for (int n = 0; n < NCH; n++) begin
      en = wm[n] && (n < (1 << ins.exec_log2));
      pb = ins.pred_en ? pm[n] : 1'b1;
      c = cond_of(ins.cmod, s0[n], s1[n]);
      sel = (ins.cmod == CM_NONE) ? pb : c;
      if (en && ins.opcode == OP_BREAK) begin
        any_en = 1'b1;
        all_hit &= pb;
        if (!ins.spf_mode) per_channel_pointer_m[n] = pb ? ip0 + sx(of.update_off) : ip0 + 32'h1;
      end
      if (en && ins.opcode == OP_CASE) begin
        any_sel |= sel;
        per_channel_pointer_m[n] = sel ? ip0 + 32'h1 : ip0 + sx(dj);
      end
      if (en && ins.opcode == OP_CMP) begin
        bits[n] = c;
        if (!ins.dst_null) dlsb_m[n] = c;
      end
    end
    jt = (ins.opcode == OP_BREAK && any_en && all_hit) || (ins.opcode == OP_CASE && !any_sel);
    ip_e = !jt ? ip0 + 32'h1 : ip0 + sx(ins.opcode == OP_BREAK ? of.jump_off : dj);
    if (ins.opcode == OP_CMP) begin
      if (ins.exec_log2 > HALF_LOG2) flag_m = bits;
      else if (ins.second_half_select) flag_m[15:8] = bits[7:0];
      else flag_m[7:0] = bits[7:0];
    end
    st = '0;
    st.jump_taken = jt;
    st.bad_opcode = !(ins.opcode inside {OP_BREAK, OP_CASE, OP_CMP});
    st.bad_cmod = bad_cm;
    rd(ADR_IP, ip_e, '1);
    rd(ADR_GO, st, '1);
    for (int n = 0; n < NCH; n++) rd({RGN_PER_CHANNEL_POINTER, 4'(n), 2'h0}, per_channel_pointer_m[n], '1);
    rd(ADR_FLAG, {16'h0, flag_m}, 32'hffff);
    rd(ADR_DLSB, {16'h0, dlsb_m}, 32'hffff);
  endtask : run_op

  // ------------------------------------------------------------------
  // Monitor and watchdog
  // ------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rd_s === 1'b1 && wreq === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("[FAIL] %0t read with no expectation", $time);
      end else begin
        got = exp_q.pop_front();
        check(rdata & got.mask, got.val & got.mask);
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
    end
  end

  initial begin
    instr_t         ins;
    offs_t          of;
    logic [NCH-1:0] wm, pm;
    void'($urandom(57443));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(ADR_INSTR, RST_WORD, '1);
    rd(ADR_IP, RST_WORD, '1);
    wr(8'h24, 32'h5a5a_a5a5);
    rd(8'h24, UNMAPPED_RD, '1);
    for (int k = 0; k < 30; k++) begin
      ins = '0;
      wm = 16'($urandom);
      pm = 16'($urandom);
      // Offsets picked at random; only break k == 3 forces jump equal to update
      of = offs_t'($urandom);
      ins.exec_log2 = 3'($urandom_range(0, 4));
      ins.second_half_select = 1'($urandom);
      ins.dst_null = 1'($urandom);
      if (k < 8) begin
        ins.opcode = OP_BREAK;
        ins.pred_en = (k != 3);
        ins.spf_mode = (k == 5);
        if (k % 2 == 1) pm = pm | wm;
        if (k == 3) of.jump_off = of.update_off;
      end else if (k < 18) begin
        ins.opcode = OP_CASE;
        ins.cmod = (k < 12) ? CM_NONE : 4'(k - 11);
        ins.pred_en = (k < 12);
        if (k == 9) pm = '0;
      end else begin
        ins.opcode = OP_CMP;
        ins.cmod = 4'((k - 18) % 6 + 1);
        if (k >= 24) ins.exec_log2 = 3'h4;
      end
      run_op(ins, of, 16'($urandom), wm, pm);
    end
    ins.opcode = 7'h11;
    run_op(ins, of, 16'h0001, wm, pm);
    ins.opcode = OP_CMP;
    ins.cmod = CM_NONE;
    run_op(ins, of, 16'h0001, wm, pm);
    report_and_stop();
  end
endmodule : simd_break_case_compare_exec_tb

`default_nettype wire
